// [hdl/asp_map.vh]
// register map, field positions, reset values and timing counts of the serial port control
// assumes: included by the port control top and its transmit and receive engines
`ifndef ASP_MAP_VH
`define ASP_MAP_VH
`define ASP_OFS_CTRL     8'h00
`define ASP_OFS_FMT      8'h04
`define ASP_OFS_STAT     8'h08
`define ASP_OFS_TXH      8'h0C
`define ASP_OFS_RXH      8'h10
`define ASP_B_TXE_IE     7
`define ASP_B_RX_IE      6
`define ASP_B_TX_EN      5
`define ASP_B_RX_EN      4
`define ASP_B_WAKE_IE    3
`define ASP_B_TXD_IE     2
`define ASP_B_CLK_HI     1
`define ASP_B_CLK_LO     0
`define ASP_F_SYNC       7
`define ASP_F_CHR7       6
`define ASP_F_PAR_EN     5
`define ASP_F_ODD        4
`define ASP_F_STOP2      3
`define ASP_F_MULTI_DROP 2
`define ASP_S_TX_EMPTY   7
`define ASP_S_RX_FULL    6
`define ASP_S_OVERRUN    5
`define ASP_S_FRAMING    4
`define ASP_S_PARITY     3
`define ASP_S_TX_DONE    2
`define ASP_S_WAKE       1
`define ASP_S_WAKE_TX    0
`define ASP_CTRL_RST     8'h00
`define ASP_FMT_RST      8'h00
`define ASP_TXH_RST      8'hFF
`define ASP_RXH_RST      8'h00
`define ASP_BASE_DIV     10'h004
`define ASP_OS_LAST      4'hF
`define ASP_OS_MID       4'h7
`define ASP_SYNC_LAST    4'h8
`endif

// [hdl/asp_tx.v]
// transmit engine: sends a prepared frame vector, lowest index first
// assumes: ticks are one-cycle pulses on hclk, frame and last index stable at load
`timescale 1ns/100ps
`include "asp_map.vh"
module asp_tx (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        en,
	input  wire        sync_mode,
	input  wire        os_tick,
	input  wire        bit_fall,
	input  wire        load,
	input  wire [11:0] frame,
	input  wire [3:0]  last_idx,
	output reg         busy,
	output reg         txd,
	output reg         last_bit
);
	reg  [11:0] f_reg;
	reg  [3:0]  idx_reg;
	reg  [3:0]  last_reg;
	reg  [3:0]  cnt_reg;
	wire        step;

	// sync data changes on the falling clock edge so the far end samples on the rise
	assign step = busy & (sync_mode ? bit_fall : (os_tick & (cnt_reg == `ASP_OS_LAST)));

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			f_reg    <= 12'hFFF;
			idx_reg  <= 4'h0;
			last_reg <= 4'h0;
			cnt_reg  <= 4'h0;
			busy     <= 1'b0;
			txd      <= 1'b1;
			last_bit <= 1'b0;
		end else begin
			last_bit <= 1'b0;
			if (!en) begin
				busy <= 1'b0;
				txd  <= 1'b1;
			end else if (load) begin
				f_reg    <= frame;
				last_reg <= last_idx;
				idx_reg  <= 4'h0;
				cnt_reg  <= 4'h0;
				busy     <= 1'b1;
				txd      <= sync_mode ? 1'b1 : frame[0];
			end else begin
				if (busy && os_tick)
					cnt_reg <= cnt_reg + 4'h1;
				if (step) begin
					if (idx_reg == last_reg) begin
						busy     <= 1'b0;
						txd      <= 1'b1;
						last_bit <= 1'b1;
					end else begin
						idx_reg <= idx_reg + 4'h1;
						txd     <= f_reg[idx_reg + 4'h1];
					end
				end
			end
		end
	end
endmodule // asp_tx

// [hdl/asp_rx.v]
// receive engine: collects samples into a frame vector, one pulse per finished frame
// assumes: rxd already synchronised, ticks are one-cycle pulses on hclk
`timescale 1ns/100ps
`include "asp_map.vh"
module asp_rx (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        en,
	input  wire        sync_mode,
	input  wire        os_tick,
	input  wire        bit_rise,
	input  wire        rxd,
	input  wire [3:0]  last_idx,
	output reg         done,
	output reg  [11:0] frame
);
	reg        busy_reg;
	reg  [3:0] idx_reg;
	reg  [3:0] cnt_reg;

	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_reg <= 1'b0;
			idx_reg  <= 4'h0;
			cnt_reg  <= 4'h0;
			done     <= 1'b0;
			frame    <= 12'hFFF;
		end else begin
			done <= 1'b0;
			if (!en) begin
				busy_reg <= 1'b0;
				idx_reg  <= sync_mode ? 4'h1 : 4'h0;
			end else if (sync_mode) begin
				if (bit_rise) begin
					frame[idx_reg] <= rxd;
					done           <= (idx_reg == last_idx);
					idx_reg        <= (idx_reg == last_idx) ? 4'h1 : idx_reg + 4'h1;
				end
			end else if (!busy_reg) begin
				if (os_tick && !rxd) begin
					busy_reg <= 1'b1;
					cnt_reg  <= 4'h0;
					idx_reg  <= 4'h0;
				end
			end else if (os_tick) begin
				cnt_reg <= cnt_reg + 4'h1;
				// mid-bit sampling; a start bit high at mid is a glitch
				if (cnt_reg == `ASP_OS_MID) begin
					if (idx_reg == 4'h0 && rxd) begin
						busy_reg <= 1'b0;
					end else begin
						frame[idx_reg] <= rxd;
						if (idx_reg == last_idx) begin
							busy_reg <= 1'b0;
							done     <= 1'b1;
						end else begin
							idx_reg <= idx_reg + 4'h1;
						end
					end
				end
			end
		end
	end
endmodule // asp_rx

// [hdl/asp_port_ctrl.v]
// serial port control register, status flags, request outputs and clock pin steering
// assumes: single AHB-Lite master, hready fed back from hreadyout, standby on hclk
//
// The implementer's own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "asp_map.vh"
module asp_port_ctrl (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	input  wire        standby,
	input  wire        rxd_i,
	output wire        txd_o,
	input  wire        sck_i,
	output reg         sck_o,
	output reg         sck_oe,
	output reg         tx_empty_irq,
	output reg         rx_full_irq,
	output reg         rx_error_irq,
	output reg         tx_done_irq
);
	reg  [7:0]  port_control_reg;
	reg  [7:0]  frame_format_reg;
	reg  [7:0]  tx_holding_reg;
	reg  [7:0]  rx_holding_reg;
	reg  [7:0]  hrdata_reg;
	reg  [7:0]  armed_reg;
	reg  [7:0]  ap_addr_reg;
	reg         ap_wr_reg;
	reg         rd_pend_reg;
	reg         tx_empty_flag;
	reg         rx_full_flag;
	reg         overrun_flag;
	reg         framing_error_flag;
	reg         parity_error_flag;
	reg         tx_done_flag;
	reg         wake_flag_bit;
	reg         wake_tx_bit;
	reg         tx_load_reg;
	reg  [11:0] tx_frame_reg;
	reg  [9:0]  div_reg;
	reg  [3:0]  os16_reg;
	reg         sck_int_reg;
	reg         rxd_s1;
	reg         rxd_s2;
	reg         sck_s1;
	reg         sck_s2;
	reg         sck_s3;
	reg  [7:0]  rd_mux;
	reg  [7:0]  ctrl_next;

	wire        tx_busy;
	wire        tx_last;
	wire        rx_done;
	wire [11:0] rx_v;

	// single-bit views of the control and format registers
	wire tx_empty_irq_enable = port_control_reg[`ASP_B_TXE_IE];
	wire rx_irq_enable       = port_control_reg[`ASP_B_RX_IE];
	wire tx_enable_bit       = port_control_reg[`ASP_B_TX_EN];
	wire rx_enable_bit       = port_control_reg[`ASP_B_RX_EN];
	wire wake_irq_enable     = port_control_reg[`ASP_B_WAKE_IE];
	wire tx_done_irq_enable  = port_control_reg[`ASP_B_TXD_IE];
	wire clock_source_hi     = port_control_reg[`ASP_B_CLK_HI];
	wire clock_source_lo     = port_control_reg[`ASP_B_CLK_LO];
	wire sync_mode           = frame_format_reg[`ASP_F_SYNC];
	wire chr7                = frame_format_reg[`ASP_F_CHR7] & ~sync_mode;
	wire par_en              = frame_format_reg[`ASP_F_PAR_EN] & ~sync_mode;
	wire odd_par             = frame_format_reg[`ASP_F_ODD];
	wire multi_drop_format   = frame_format_reg[`ASP_F_MULTI_DROP] & ~sync_mode;

	// parity bit that makes the character plus bit even, or odd when odd is set
	function par_calc;
		input [7:0] d;
		input       odd;
		begin
			par_calc = (^d) ^ odd;
		end
	endfunction

	// index of the last frame bit; receiver checks only the first stop bit
	function [3:0] frame_last;
		input [7:0] fmt;
		input       is_tx;
		begin
			if (fmt[`ASP_F_SYNC])
				frame_last = `ASP_SYNC_LAST;
			else
				frame_last = (fmt[`ASP_F_CHR7] ? 4'h7 : 4'h8)
					+ ((fmt[`ASP_F_MULTI_DROP] | fmt[`ASP_F_PAR_EN]) ? 4'h1 : 4'h0) + 4'h1
					+ ((is_tx & fmt[`ASP_F_STOP2]) ? 4'h1 : 4'h0);
		end
	endfunction

	// frame vector: start bit at 0, data lsb first, extra bit, stop bits as ones
	function [11:0] tx_build;
		input [7:0] d;
		input [7:0] fmt;
		input       wb;
		reg   [11:0] f;
		reg   [3:0]  p;
		reg   [7:0]  dd;
		begin
			f    = 12'hFFF;
			f[0] = 1'b0;
			dd   = fmt[`ASP_F_CHR7] ? {1'b0, d[6:0]} : d;
			p    = fmt[`ASP_F_CHR7] ? 4'h8 : 4'h9;
			if (fmt[`ASP_F_SYNC]) begin
				f[8:1] = d;
			end else begin
				f[7:1] = d[6:0];
				if (!fmt[`ASP_F_CHR7])
					f[8] = d[7];
				if (fmt[`ASP_F_MULTI_DROP])
					f[p] = wb;
				else if (fmt[`ASP_F_PAR_EN])
					f[p] = par_calc(dd, fmt[`ASP_F_ODD]);
			end
			tx_build = f;
		end
	endfunction

	// bus decode
	wire       take    = hsel & htrans[1] & hready;
	wire [7:0] wd      = hwdata[7:0];
	wire       wr_ctrl = ap_wr_reg & (ap_addr_reg == `ASP_OFS_CTRL);
	wire       wr_fmt  = ap_wr_reg & (ap_addr_reg == `ASP_OFS_FMT);
	wire       wr_stat = ap_wr_reg & (ap_addr_reg == `ASP_OFS_STAT);
	wire       wr_txh  = ap_wr_reg & (ap_addr_reg == `ASP_OFS_TXH);
	wire       rd_stat = rd_pend_reg & (ap_addr_reg == `ASP_OFS_STAT);
	wire [7:0] stat    = {tx_empty_flag, rx_full_flag, overrun_flag, framing_error_flag,
		parity_error_flag, tx_done_flag, wake_flag_bit, wake_tx_bit};
	// a flag clears only if the last status read showed it as 1; tx done clears on the tx empty bit instead of its own
	wire [7:0] clr     = {8{wr_stat}} & ~wd & armed_reg;

	// clock selection
	wire [9:0] div_lim  = (`ASP_BASE_DIV << {frame_format_reg[1:0], 1'b0}) - 10'h001;
	wire       div_tick = (div_reg == div_lim);
	wire       sck_rise = sck_s2 & ~sck_s3;
	wire       sck_fall = ~sck_s2 & sck_s3;
	wire       int_fall = div_tick & tx_busy & sck_int_reg;
	wire       int_rise = div_tick & tx_busy & ~sck_int_reg;
	wire       os_tick  = clock_source_hi ? sck_rise : div_tick;
	wire       bit_fall = clock_source_hi ? sck_fall : int_fall;
	wire       bit_rise = clock_source_hi ? sck_rise : int_rise;

	// transmit side
	wire tx_start    = tx_enable_bit & ~tx_empty_flag & ~tx_busy & ~tx_load_reg;
	wire tx_empty_nx = ~tx_enable_bit | tx_start | (tx_empty_flag & ~clr[`ASP_S_TX_EMPTY]);
	// the set wins over a clear landing in the same cycle
	wire tx_done_nx  = (tx_last & tx_empty_flag) | (tx_done_flag & ~clr[`ASP_S_TX_EMPTY]);

	// receive side
	wire [3:0] rx_last   = frame_last(frame_format_reg, 1'b0);
	wire [7:0] rx_data   = chr7 ? {1'b0, rx_v[7:1]} : rx_v[8:1];
	wire       rx_xbit   = rx_v[chr7 ? 4'h8 : 4'h9];
	wire       rx_stop   = rx_v[rx_last];
	wire       wake_act  = multi_drop_format & wake_irq_enable;
	wire       rx_skip   = wake_act & ~rx_xbit;
	wire       rx_accept = rx_done & ~rx_skip;
	wire       wake_hit  = rx_done & wake_act & rx_xbit;
	wire       full_now  = rx_full_flag & ~clr[`ASP_S_RX_FULL];
	wire       rx_load   = rx_accept & ~full_now;
	wire       ovr_set   = rx_accept & full_now;
	wire       fer_set   = rx_load & ~sync_mode & ~rx_stop;
	wire       per_set   = rx_load & par_en & ~multi_drop_format & (par_calc(rx_data, odd_par) != rx_xbit);
	wire       rx_full_nx = rx_load | full_now;
	wire       ovr_nx    = ovr_set | (overrun_flag & ~clr[`ASP_S_OVERRUN]);
	wire       fer_nx    = fer_set | (framing_error_flag & ~clr[`ASP_S_FRAMING]);
	wire       per_nx    = per_set | (parity_error_flag & ~clr[`ASP_S_PARITY]);
	wire       wake_nx   = (rx_accept & multi_drop_format) ? rx_xbit : wake_flag_bit;

	assign hrdata = {24'h000000, hrdata_reg};

	always @* begin
		case (ap_addr_reg)
			`ASP_OFS_CTRL: rd_mux = port_control_reg;
			`ASP_OFS_FMT:  rd_mux = frame_format_reg;
			`ASP_OFS_STAT: rd_mux = stat;
			`ASP_OFS_TXH:  rd_mux = tx_holding_reg;
			`ASP_OFS_RXH:  rd_mux = rx_holding_reg;
			default:       rd_mux = 8'h00;
		endcase
	end

	always @* begin
		ctrl_next = port_control_reg;
		if (wr_ctrl)
			ctrl_next = wd;
		// hardware clear of wake enable overrides a same-cycle write
		if (wake_hit)
			ctrl_next[`ASP_B_WAKE_IE] = 1'b0;
	end

	// bus slave: writes zero wait, reads one wait so hrdata comes from a flop
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_reg   <= 1'b0;
			rd_pend_reg <= 1'b0;
			ap_addr_reg <= 8'h00;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
			hrdata_reg  <= 8'h00;
		end else begin
			ap_wr_reg   <= take & hwrite & (hsize == 3'b010);
			rd_pend_reg <= take & ~hwrite;
			hreadyout   <= ~(take & ~hwrite);
			hresp       <= 1'b0;
			if (take)
				ap_addr_reg <= haddr[7:0];
			if (rd_pend_reg)
				hrdata_reg <= rd_mux;
		end
	end

	// pin synchronisers and clock generation
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rxd_s1      <= 1'b1;
			rxd_s2      <= 1'b1;
			sck_s1      <= 1'b1;
			sck_s2      <= 1'b1;
			sck_s3      <= 1'b1;
			div_reg     <= 10'h000;
			os16_reg    <= 4'h0;
			sck_int_reg <= 1'b1;
			sck_o       <= 1'b1;
			sck_oe      <= 1'b0;
		end else begin
			rxd_s1  <= rxd_i;
			rxd_s2  <= rxd_s1;
			sck_s1  <= sck_i;
			sck_s2  <= sck_s1;
			sck_s3  <= sck_s2;
			div_reg <= div_tick ? 10'h000 : div_reg + 10'h001;
			if (os_tick)
				os16_reg <= os16_reg + 4'h1;
			// internal sync clock only runs during a transmission
			if (!tx_busy)
				sck_int_reg <= 1'b1;
			else if (div_tick)
				sck_int_reg <= ~sck_int_reg;
			if (sync_mode) begin
				sck_oe <= ~clock_source_hi;
				sck_o  <= sck_int_reg;
			end else begin
				// low clock bit ignored unless async and internally clocked
				sck_oe <= ~clock_source_hi & clock_source_lo;
				sck_o  <= os16_reg[3];
			end
		end
	end

	// registers, flags and requests
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_control_reg   <= `ASP_CTRL_RST;
			frame_format_reg   <= `ASP_FMT_RST;
			tx_holding_reg     <= `ASP_TXH_RST;
			rx_holding_reg     <= `ASP_RXH_RST;
			tx_empty_flag      <= 1'b1;
			rx_full_flag       <= 1'b0;
			overrun_flag       <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			tx_done_flag       <= 1'b1;
			wake_flag_bit      <= 1'b0;
			wake_tx_bit        <= 1'b0;
			armed_reg          <= 8'h00;
			tx_load_reg        <= 1'b0;
			tx_frame_reg       <= 12'hFFF;
			tx_empty_irq       <= 1'b0;
			rx_full_irq        <= 1'b0;
			rx_error_irq       <= 1'b0;
			tx_done_irq        <= 1'b0;
		end else if (standby) begin
			port_control_reg   <= `ASP_CTRL_RST;
			frame_format_reg   <= `ASP_FMT_RST;
			tx_holding_reg     <= `ASP_TXH_RST;
			rx_holding_reg     <= `ASP_RXH_RST;
			tx_empty_flag      <= 1'b1;
			rx_full_flag       <= 1'b0;
			overrun_flag       <= 1'b0;
			framing_error_flag <= 1'b0;
			parity_error_flag  <= 1'b0;
			tx_done_flag       <= 1'b1;
			wake_flag_bit      <= 1'b0;
			wake_tx_bit        <= 1'b0;
			armed_reg          <= 8'h00;
			tx_load_reg        <= 1'b0;
			tx_empty_irq       <= 1'b0;
			rx_full_irq        <= 1'b0;
			rx_error_irq       <= 1'b0;
			tx_done_irq        <= 1'b0;
		end else begin
			port_control_reg <= ctrl_next;
			if (wr_fmt)
				frame_format_reg <= wd;
			if (wr_txh)
				tx_holding_reg <= wd;
			if (wr_stat)
				wake_tx_bit <= wd[`ASP_S_WAKE_TX];
			if (rx_load)
				rx_holding_reg <= rx_data;
			// receiver disabled means no rx_done, so none of the five receive flags below can be set
			rx_full_flag       <= rx_full_nx;
			overrun_flag       <= ovr_nx;
			framing_error_flag <= fer_nx;
			parity_error_flag  <= per_nx;
			wake_flag_bit      <= wake_nx;
			tx_empty_flag      <= tx_empty_nx;
			tx_done_flag       <= tx_done_nx;
			if (rd_pend_reg && rd_stat)
				armed_reg <= stat;
			else if (wr_stat)
				armed_reg <= 8'h00;
			tx_load_reg <= tx_start;
			if (tx_start)
				tx_frame_reg <= tx_build(tx_holding_reg, frame_format_reg, wake_tx_bit);
			// requests track the next flag and enable so both change on one edge
			tx_empty_irq <= tx_empty_nx & ctrl_next[`ASP_B_TXE_IE];
			rx_full_irq  <= rx_full_nx & ctrl_next[`ASP_B_RX_IE];
			rx_error_irq <= (ovr_nx | fer_nx | per_nx) & ctrl_next[`ASP_B_RX_IE];
			tx_done_irq  <= tx_done_nx & ctrl_next[`ASP_B_TXD_IE];
		end
	end

	asp_tx u_tx (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.en        (tx_enable_bit),
		.sync_mode (sync_mode),
		.os_tick   (os_tick),
		.bit_fall  (bit_fall),
		.load      (tx_load_reg),
		.frame     (tx_frame_reg),
		.last_idx  (frame_last(frame_format_reg, 1'b1)),
		.busy      (tx_busy),
		.txd       (txd_o),
		.last_bit  (tx_last)
	);

	asp_rx u_rx (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.en        (rx_enable_bit),
		.sync_mode (sync_mode),
		.os_tick   (os_tick),
		.bit_rise  (bit_rise),
		.rxd       (rxd_s2),
		.last_idx  (rx_last),
		.done      (rx_done),
		.frame     (rx_v)
	);
endmodule // asp_port_ctrl

// [tb/asp_port_ctrl_asserts.sv]
// port-level checks of the serial port control top
// assumes: bound to asp_port_ctrl, hready is hreadyout fed back
`timescale 1ns/100ps
module asp_port_ctrl_asserts (
	input logic        hclk,
	input logic        hresetn,
	input logic        hsel,
	input logic [31:0] haddr,
	input logic [1:0]  htrans,
	input logic        hwrite,
	input logic [2:0]  hsize,
	input logic [31:0] hwdata,
	input logic        hready,
	input logic [31:0] hrdata,
	input logic        hreadyout,
	input logic        hresp,
	input logic        standby,
	input logic        txd_o,
	input logic        tx_empty_irq,
	input logic        rx_full_irq,
	input logic        rx_error_irq,
	input logic        tx_done_irq
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	wire take   = hsel && htrans[1] && hready;
	wire wr_ctl = take && hwrite && hsize == 3'h2 && haddr[7:0] == 8'h00;
	wire any    = tx_empty_irq | rx_full_irq | rx_error_irq | tx_done_irq;
	a_boot_quiet: assert property (!$past(hresetn) |-> !any)
		else $error("request active after reset");
	a_stby_clear: assert property (standby |=> !any)
		else $error("request survives standby");
	a_stby_txd: assert property (standby |-> ##2 txd_o)
		else $error("line not idle after standby");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response");
	a_read_narrow: assert property (take && !hwrite |-> ##2 hrdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_txe_gate: assert property (wr_ctl ##1 !hwdata[7] |=> !tx_empty_irq)
		else $error("tx empty request with enable clear");
	a_rx_gate: assert property (wr_ctl ##1 !hwdata[6] |=> !(rx_full_irq | rx_error_irq))
		else $error("receive request with enable clear");
	a_txd_gate: assert property (wr_ctl ##1 !hwdata[2] |=> !tx_done_irq)
		else $error("tx done request with enable clear");
	c_tx_done: cover property ($rose(tx_done_irq));
	c_rx_full: cover property ($rose(rx_full_irq));
	c_rx_err: cover property ($rose(rx_error_irq));
endmodule // asp_port_ctrl_asserts
bind asp_port_ctrl asp_port_ctrl_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
	.hreadyout(hreadyout), .hresp(hresp), .standby(standby), .txd_o(txd_o), .tx_empty_irq(tx_empty_irq),
	.rx_full_irq(rx_full_irq), .rx_error_irq(rx_error_irq), .tx_done_irq(tx_done_irq));

// [tb/asp_link_model.sv]
// far end of the serial line: sends async frames, captures transmitted bytes
// assumes: 8 data bits, no parity, receive bit time given in tx_ns
`timescale 1ns/100ps
module asp_link_model (
	output logic rxd,
	output logic sck,
	input  logic txd
);
	int         tx_ns = 320;
	int         n_got = 0;
	logic [7:0] got;
	logic       ext = 1'b0;
	initial begin
		rxd = 1'b1;
		sck = 1'b0;
	end
	// 16x clock runs only around a frame, stands at 0 otherwise
	always #40 if (ext) sck = ~sck;
	task send(input logic [7:0] d, input logic mp, input logic wb, input int bns, input logic xc);
		logic [10:0] f;
		f = mp ? {1'b1, wb, d, 1'b0} : {2'b11, d, 1'b0};
		ext = xc;
		#(bns * 2);
		for (int i = 0; i < 11; i++) begin
			rxd = f[i];
			#(bns);
		end
		ext = 1'b0;
	endtask
	always begin
		@(negedge txd);
		#(tx_ns * 3 / 2);
		for (int i = 0; i < 8; i++) begin
			got[i] = txd;
			#(tx_ns);
		end
		n_got++;
	end
endmodule // asp_link_model

// [tb/asp_port_ctrl_tb.sv]
// self-checking bench for the serial port control top
// assumes: one bus master here, link model on the serial pins
`timescale 1ns/100ps
module asp_port_ctrl_tb;
	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, standby;
	logic [31:0] haddr, hwdata, rv;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, txd, sck_o, sck_oe, rxd, lsck;
	wire         t_e, r_f, r_e, t_d;
	wire  [3:0]  irqs = {t_d, r_e, r_f, t_e};
	wire         sck_pin = sck_oe ? sck_o : lsck;
	int          fail_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	int          t0;
	logic [7:0]  ctl [6] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h01, 8'h02};
	logic [7:0]  fmt [6] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80};
	logic        oe  [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
	asp_port_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .standby(standby), .rxd_i(rxd), .txd_o(txd), .sck_i(sck_pin),
		.sck_o(sck_o), .sck_oe(sck_oe), .tx_empty_irq(t_e), .rx_full_irq(r_f), .rx_error_irq(r_e),
		.tx_done_irq(t_d));
	asp_link_model link (.rxd(rxd), .sck(lsck), .txd(txd));
	always #2.5 hclk = ~hclk;
	task summarize;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// hang guard, well above the longest expected run
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			summarize;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		{hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
		// ready is looked at before the edge that samples it, not in that edge's own time step
		do @(negedge hclk); while (hreadyout !== 1'b1);
		@(posedge hclk);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
		do @(negedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
		@(posedge hclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d, rv);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0, rv);
		chk(rv, e);
	endtask
	// requests are compared after the edge's updates have landed
	task chki(input logic [3:0] e);
		@(negedge hclk);
		chk(irqs, e);
	endtask
	task await_irq(input int k);
		for (int i = 0; i < 8000 && irqs[k] !== 1'b1; i++) @(posedge hclk);
	endtask
	task clr_rx;
		xfer(1'b0, 8'h08, 32'h0, rv);
		wr(8'h08, 32'h84);
	endtask
	initial begin
		{hresetn, standby, hsel, htrans, hwrite, haddr, hwdata} = '0;
		hsize = 3'h2;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		rdc(8'h00, 32'h00);
		rdc(8'h08, 32'h84);
		wr(8'h00, 32'hFF);
		rdc(8'h00, 32'hFF);
		chki(4'h9);
		@(posedge hclk);
		standby <= 1'b1;
		@(posedge hclk);
		standby <= 1'b0;
		rdc(8'h00, 32'h00);
		chki(4'h0);
		wr(8'h00, 32'h80);
		rdc(8'h08, 32'h84);
		// tx empty stays locked, but the same clear still drops tx done
		wr(8'h08, 32'h00);
		rdc(8'h08, 32'h80);
		chki(4'h1);
		wr(8'h00, 32'hA4);
		wr(8'h0C, 32'h55);
		rdc(8'h08, 32'h80);
		wr(8'h08, 32'h00);
		t0 = cyc;
		chki(4'h0);
		await_irq(3);
		chk(cyc - t0 > 600, 1);
		chk(link.got, 8'h55);
		chki(4'h9);
		wr(8'h00, 32'h24);
		chki(4'h8);
		wr(8'h00, 32'h20);
		chki(4'h0);
		wr(8'h00, 32'h50);
		link.send(8'hA5, 1'b0, 1'b0, 320, 1'b0);
		await_irq(1);
		rdc(8'h10, 32'hA5);
		chki(4'h2);
		link.send(8'h3C, 1'b0, 1'b0, 320, 1'b0);
		await_irq(2);
		chki(4'h6);
		wr(8'h00, 32'h40);
		rdc(8'h08, 32'hE4);
		wr(8'h00, 32'h00);
		chki(4'h0);
		wr(8'h00, 32'h40);
		chki(4'h6);
		rdc(8'h08, 32'hE4);
		wr(8'h08, 32'h84);
		chki(4'h0);
		wr(8'h04, 32'h04);
		wr(8'h00, 32'h58);
		link.send(8'h11, 1'b1, 1'b0, 320, 1'b0);
		chki(4'h0);
		rdc(8'h00, 32'h58);
		link.send(8'h22, 1'b1, 1'b1, 320, 1'b0);
		await_irq(1);
		rdc(8'h00, 32'h50);
		rdc(8'h08, 32'hC6);
		rdc(8'h10, 32'h22);
		clr_rx;
		wr(8'h04, 32'h00);
		wr(8'h00, 32'h58);
		link.send(8'h33, 1'b0, 1'b0, 320, 1'b0);
		await_irq(1);
		rdc(8'h10, 32'h33);
		clr_rx;
		// even parity, extra bit sent wrong for one set data bit
		wr(8'h04, 32'h20);
		wr(8'h00, 32'h50);
		link.send(8'h01, 1'b1, 1'b0, 320, 1'b0);
		await_irq(2);
		chki(4'h6);
		rdc(8'h08, 32'hCE);
		rdc(8'h10, 32'h01);
		wr(8'h08, 32'h84);
		chki(4'h0);
		wr(8'h04, 32'h00);
		wr(8'h00, 32'h52);
		link.send(8'h6B, 1'b0, 1'b0, 1280, 1'b1);
		await_irq(1);
		rdc(8'h10, 32'h6B);
		// clock bits first, then the mode
		for (int i = 0; i < 6; i++) begin
			wr(8'h00, {24'h0, ctl[i]});
			wr(8'h04, {24'h0, fmt[i]});
			// pin enable follows the format one edge after it lands
			repeat (2) @(negedge hclk);
			chk(sck_oe, oe[i]);
		end
		wr(8'h00, 32'h01);
		wr(8'h04, 32'h00);
		@(posedge sck_o);
		t0 = cyc;
		@(posedge sck_o);
		chk(cyc - t0, 64);
		summarize;
	end
endmodule // asp_port_ctrl_tb
